// ===== logic/aio_defines.svh
// register map, field positions, reset values and range thresholds
// assumes samples arrive as signed 18-bit codes, 32768 codes per range full scale
`ifndef AIO_DEFINES_SVH
`define AIO_DEFINES_SVH

// byte offsets on the register bus
`define AIO_OFF_FLAGS 8'h00
`define AIO_OFF_STS 8'h04
`define AIO_OFF_MASK 8'h08
`define AIO_OFF_CFG 8'h10
`define AIO_OFF_RAW_IN 8'h20
`define AIO_OFF_SCALED_IN 8'h30
`define AIO_OFF_IN_RAW_LIM 8'h40
`define AIO_OFF_IN_EU_LIM 8'h50
`define AIO_OFF_OUT_EU_LIM 8'h60
`define AIO_OFF_OUT_RAW_LIM 8'h70
`define AIO_OFF_SCALED_OUT 8'h80
`define AIO_OFF_RAW_OUT 8'h90

// channel configuration fields
`define AIO_CFG_RNG_LSB 0
`define AIO_CFG_FILT_LSB 3
`define AIO_CFG_IN_SC_BIT 6
`define AIO_CFG_IN_CL_BIT 7
`define AIO_CFG_OUT_SC_BIT 8
`define AIO_CFG_OUT_CL_BIT 9
// limit registers: minimum low half, maximum high half
`define AIO_LIM_MIN_LSB 0
`define AIO_LIM_MAX_LSB 16
// event status layout: faults low nibble, new averages high nibble
`define AIO_STS_FAULT_LSB 0
`define AIO_STS_NEW_LSB 4

// reset values
`define AIO_RST_MASK 8'h00
`define AIO_RST_RANGE 3'h3
`define AIO_RST_LIM_MIN 16'h0000
`define AIO_RST_LIM_MAX 16'h7FFF

// raw count limits
`define AIO_RAW_MIN_BI 18'sh38000
`define AIO_RAW_MAX 18'sh07FFF
`define AIO_RAW_MIN_UNI 18'sh00000
`define AIO_RAW_MIN_LIVE0 18'sh01999

// fault thresholds in sample codes
`define AIO_TH_FULL_HI 18'sh08000
`define AIO_TH_FULL_LO 18'sh38000
`define AIO_TH_5V05_HI 18'sh08147
`define AIO_TH_5V05_LO 18'sh37EB9
`define AIO_TH_2MA 18'sh00CCD
`define AIO_TH_10V_NEG 18'sh3FF5D
`define AIO_TH_5V_NEG 18'sh3FEB9

`endif

// ===== logic/aio_pkg.sv
// types shared by the range, scaling and status logic
// assumes aio_defines.svh supplies the numeric constants
package aio_pkg;

    // input range selections
    typedef enum logic [2:0] {
        RNG_BI20MA,
        RNG_4_20MA,
        RNG_UNI10V,
        RNG_UNI5V,
        RNG_BI10V,
        RNG_BI5V
    } range_t;

endpackage

// ===== logic/aio_linear_scale.sv
// two-point linear scaler with optional clamp, purely combinational
// assumes the caller registers the result
`timescale 1ns/1ps
module aio_linear_scale (
    input wire logic [15:0] i_x,
    input wire logic [15:0] i_x_min,
    input wire logic [15:0] i_x_max,
    input wire logic [15:0] i_y_min,
    input wire logic [15:0] i_y_max,
    input wire logic i_clamp,
    output logic [15:0] o_y
);
    logic signed [16:0] dx, dx_span, dy_span;
    logic signed [33:0] num;
    logic [33:0] mag, quo;
    logic [16:0] den;
    logic neg;
    logic signed [35:0] y, lo, hi;

    always_comb begin
        dx = 17'($signed(i_x)) - 17'($signed(i_x_min));
        dx_span = 17'($signed(i_x_max)) - 17'($signed(i_x_min));
        dy_span = 17'($signed(i_y_max)) - 17'($signed(i_y_min));
        num = 34'(dx) * 34'(dy_span);
        neg = num[33] ^ dx_span[16];
        mag = num[33] ? 34'(-num) : 34'(num);
        den = dx_span[16] ? 17'(-dx_span) : 17'(dx_span);
        // round half away from zero; degenerate span yields the minimum
        if (den == 17'h00000) begin
            quo = 34'h000000000;
        end else begin
            quo = (mag + 34'(den >> 1)) / 34'(den);
        end
        y = 36'($signed(i_y_min)) + (neg ? -$signed({2'b00, quo}) : $signed({2'b00, quo}));
        if ($signed(i_y_min) <= $signed(i_y_max)) begin
            lo = 36'($signed(i_y_min));
            hi = 36'($signed(i_y_max));
        end else begin
            lo = 36'($signed(i_y_max));
            hi = 36'($signed(i_y_min));
        end
        if (i_clamp && y < lo) begin
            y = lo;
        end else if (i_clamp && y > hi) begin
            y = hi;
        end
        // extrapolation beyond 16 bits saturates
        if (y > 36'sh000007FFF) begin
            o_y = 16'h7FFF;
        end else if (y < -36'sh000008000) begin
            o_y = 16'h8000;
        end else begin
            o_y = y[15:0];
        end
    end
endmodule

// ===== logic/aio_range_scale_status.sv
// range coding, fault flags, averaging and scaling for a 4-in/4-out analog module
// assumes one converted sample per i_adc_valid pulse, APB master on the same clock
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "aio_defines.svh"

// What this block does
// - bipolar ranges report signed raw counts over the full 16-bit range.
// - 4-20 mA maps onto raw counts 6553 to 32767, 0.61 uA each.
// - unipolar voltage ranges give counts 0 to 32767, 305 or 153 uV each.
// - status byte is the first eight bits of free discrete input space.
// - status byte low nibble holds channel faults 1..4, upper nibble unused.
// - a channel's fault flag sets when its input meets its range's error condition.
// - 4-20 mA faults below 2.0 mA, with no upper limit.
// - +/-20 mA faults below -20.0 mA or above 20.0 mA.
// - 0-10 V faults below -0.05 V or above 10.0 V.
// - 0-5 V faults below -0.05 V or above 5.05 V.
// - +/-10 V faults outside 10.0 V; +/-5 V faults outside 5.05 V.
// - each input has its own range and averaging filter time.
// - input scaling maps raw min..max linearly onto engineering min..max.
// - with input scaling on, input clamp limits scaled value to engineering min and max.
// - output scaling maps engineering min..max linearly onto raw output limits.
// - with output scaling on, output clamp limits raw output to its configured min and max.
// - full 16-bit resolution only on bipolar ranges; unipolar uses positive half.
module aio_range_scale_status
    import aio_pkg::*;
#(
    parameter int NUM_CH = 4,
    parameter int FILT_W = 3
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_adc_valid,
    input wire logic [1:0] i_adc_chan,
    input wire logic [17:0] i_adc_data,
    output logic [7:0] o_fault_flags,
    output logic [NUM_CH-1:0][15:0] o_dac_code,
    output logic o_irq
);
    // the address map has room for four channels per group
    localparam int MAXSH = (1 << FILT_W) - 1;
    localparam int ACC_W = 16 + MAXSH;
    localparam int CNT_W = MAXSH;

    typedef struct packed {
        range_t [NUM_CH-1:0] rng;
        logic [NUM_CH-1:0][FILT_W-1:0] filt;
        logic [NUM_CH-1:0] in_sc;
        logic [NUM_CH-1:0] in_cl;
        logic [NUM_CH-1:0] out_sc;
        logic [NUM_CH-1:0] out_cl;
        logic [NUM_CH-1:0][15:0] in_rmin;
        logic [NUM_CH-1:0][15:0] in_rmax;
        logic [NUM_CH-1:0][15:0] in_emin;
        logic [NUM_CH-1:0][15:0] in_emax;
        logic [NUM_CH-1:0][15:0] out_emin;
        logic [NUM_CH-1:0][15:0] out_emax;
        logic [NUM_CH-1:0][15:0] out_rmin;
        logic [NUM_CH-1:0][15:0] out_rmax;
        logic [NUM_CH-1:0][15:0] out_eu;
        logic [NUM_CH-1:0][15:0] raw_in;
        logic [NUM_CH-1:0][15:0] scaled_in;
        logic [NUM_CH-1:0][15:0] raw_out;
        logic [NUM_CH-1:0][ACC_W-1:0] acc;
        logic [NUM_CH-1:0][CNT_W-1:0] cnt;
        logic [NUM_CH-1:0] flags;
        logic [7:0] sts;
        logic [7:0] mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

    state_t q_q, q_d;
    logic [NUM_CH-1:0][15:0] in_y, out_y;

    // one word of the flag/status/mask group; byte-lane address bits are ignored
    function automatic logic word_is(logic [7:0] a, logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    // saturate a sample code into a raw count window
    function automatic logic [15:0] fit(logic [17:0] s, logic [17:0] lo, logic [17:0] hi);
        logic [17:0] r;
        r = s;
        if ($signed(s) < $signed(lo)) begin
            r = lo;
        end else if ($signed(s) > $signed(hi)) begin
            r = hi;
        end
        return r[15:0];
    endfunction

    // sample code to {fault, raw count} for the selected range
    function automatic logic [16:0] conv(range_t r, logic [17:0] s);
        logic f;
        logic [15:0] raw;
        f = 1'b0;
        raw = fit(s, `AIO_RAW_MIN_BI, `AIO_RAW_MAX);
        case (r)
            RNG_BI20MA, RNG_BI10V: begin
                f = $signed(s) > $signed(`AIO_TH_FULL_HI)
                    || $signed(s) < $signed(`AIO_TH_FULL_LO);
                raw = fit(s, `AIO_RAW_MIN_BI, `AIO_RAW_MAX);
            end
            RNG_BI5V: begin
                f = $signed(s) > $signed(`AIO_TH_5V05_HI)
                    || $signed(s) < $signed(`AIO_TH_5V05_LO);
                raw = fit(s, `AIO_RAW_MIN_BI, `AIO_RAW_MAX);
            end
            RNG_4_20MA: begin
                // broken loop only; overrange is not a fault here
                f = $signed(s) < $signed(`AIO_TH_2MA);
                raw = fit(s, `AIO_RAW_MIN_LIVE0, `AIO_RAW_MAX);
            end
            RNG_UNI10V: begin
                f = $signed(s) < $signed(`AIO_TH_10V_NEG)
                    || $signed(s) > $signed(`AIO_TH_FULL_HI);
                raw = fit(s, `AIO_RAW_MIN_UNI, `AIO_RAW_MAX);
            end
            RNG_UNI5V: begin
                f = $signed(s) < $signed(`AIO_TH_5V_NEG)
                    || $signed(s) > $signed(`AIO_TH_5V05_HI);
                raw = fit(s, `AIO_RAW_MIN_UNI, `AIO_RAW_MAX);
            end
            default: begin
                // codes 6 and 7 act as a bipolar range that never faults
                f = 1'b0;
            end
        endcase
        return {f, raw};
    endfunction

    for (genvar g = 0; g < NUM_CH; g++) begin : g_scale
        aio_linear_scale u_in (
            .i_x(q_q.raw_in[g]),
            .i_x_min(q_q.in_rmin[g]),
            .i_x_max(q_q.in_rmax[g]),
            .i_y_min(q_q.in_emin[g]),
            .i_y_max(q_q.in_emax[g]),
            .i_clamp(q_q.in_cl[g]),
            .o_y(in_y[g])
        );
        aio_linear_scale u_out (
            .i_x(q_q.out_eu[g]),
            .i_x_min(q_q.out_emin[g]),
            .i_x_max(q_q.out_emax[g]),
            .i_y_min(q_q.out_rmin[g]),
            .i_y_max(q_q.out_rmax[g]),
            .i_clamp(q_q.out_cl[g]),
            .o_y(out_y[g])
        );
    end

    always_comb begin
        logic [16:0] cv;
        logic [ACC_W-1:0] sum;
        logic [ACC_W-1:0] avg;
        logic [CNT_W-1:0] last;
        logic [7:0] ev_set;
        logic [7:0] ev_clr;
        logic [7:0] grp;
        logic [1:0] ch;
        logic ch_ok;
        logic wr;
        logic [31:0] rd;
        logic err;
        cv = 17'h00000;
        sum = '0;
        avg = '0;
        last = '0;
        ev_set = 8'h00;
        ev_clr = 8'h00;
        grp = 8'(i_paddr[7:4]);
        ch = i_paddr[3:2];
        ch_ok = int'(ch) < NUM_CH;
        wr = 1'b0;
        rd = 32'h00000000;
        err = 1'b0;
        q_d = q_q;

        // sample path: flag every update, average over 2^filt updates
        if (i_adc_valid && int'(i_adc_chan) < NUM_CH) begin
            cv = conv(q_q.rng[i_adc_chan], i_adc_data);
            // fault judges the raw sample, not the average, so a spike shows at once
            q_d.flags[i_adc_chan] = cv[16];
            if (cv[16] && !q_q.flags[i_adc_chan]) begin
                ev_set[`AIO_STS_FAULT_LSB + int'(i_adc_chan)] = 1'b1;
            end
            sum = q_q.acc[i_adc_chan] + ACC_W'($signed(cv[15:0]));
            last = CNT_W'((32'd1 << q_q.filt[i_adc_chan]) - 32'd1);
            // a shortened window closes at once rather than overflowing
            if (q_q.cnt[i_adc_chan] >= last) begin
                avg = ACC_W'($signed(sum) >>> q_q.filt[i_adc_chan]);
                q_d.raw_in[i_adc_chan] = avg[15:0];
                q_d.acc[i_adc_chan] = '0;
                q_d.cnt[i_adc_chan] = '0;
                ev_set[`AIO_STS_NEW_LSB + int'(i_adc_chan)] = 1'b1;
            end else begin
                q_d.acc[i_adc_chan] = sum;
                q_d.cnt[i_adc_chan] = q_q.cnt[i_adc_chan] + CNT_W'(1);
            end
        end

        // scaling results, one cycle behind their operands
        for (int c = 0; c < NUM_CH; c++) begin
            q_d.scaled_in[c] = q_q.in_sc[c] ? in_y[c] : q_q.raw_in[c];
            q_d.raw_out[c] = q_q.out_sc[c] ? out_y[c] : q_q.out_eu[c];
        end

        // register read decode
        case (grp)
            `AIO_OFF_FLAGS >> 4: begin
                if (word_is(i_paddr, `AIO_OFF_FLAGS)) begin
                    rd = 32'(q_q.flags);
                end else if (word_is(i_paddr, `AIO_OFF_STS)) begin
                    rd = 32'(q_q.sts);
                end else if (word_is(i_paddr, `AIO_OFF_MASK)) begin
                    rd = 32'(q_q.mask);
                end else begin
                    err = 1'b1;
                end
            end
            `AIO_OFF_CFG >> 4: begin
                rd[`AIO_CFG_RNG_LSB +: 3] = q_q.rng[ch];
                rd[`AIO_CFG_FILT_LSB +: FILT_W] = q_q.filt[ch];
                rd[`AIO_CFG_IN_SC_BIT] = q_q.in_sc[ch];
                rd[`AIO_CFG_IN_CL_BIT] = q_q.in_cl[ch];
                rd[`AIO_CFG_OUT_SC_BIT] = q_q.out_sc[ch];
                rd[`AIO_CFG_OUT_CL_BIT] = q_q.out_cl[ch];
            end
            `AIO_OFF_RAW_IN >> 4: rd = 32'($signed(q_q.raw_in[ch]));
            `AIO_OFF_SCALED_IN >> 4: rd = 32'($signed(q_q.scaled_in[ch]));
            `AIO_OFF_IN_RAW_LIM >> 4: rd = {q_q.in_rmax[ch], q_q.in_rmin[ch]};
            `AIO_OFF_IN_EU_LIM >> 4: rd = {q_q.in_emax[ch], q_q.in_emin[ch]};
            `AIO_OFF_OUT_EU_LIM >> 4: rd = {q_q.out_emax[ch], q_q.out_emin[ch]};
            `AIO_OFF_OUT_RAW_LIM >> 4: rd = {q_q.out_rmax[ch], q_q.out_rmin[ch]};
            `AIO_OFF_SCALED_OUT >> 4: rd = 32'($signed(q_q.out_eu[ch]));
            `AIO_OFF_RAW_OUT >> 4: rd = 32'($signed(q_q.raw_out[ch]));
            default: err = 1'b1;
        endcase
        if (grp != (`AIO_OFF_FLAGS >> 4) && !ch_ok) begin
            err = 1'b1;
            rd = 32'h00000000;
        end

        // apb: answer registered in setup, completes in the first access cycle
        // prdata holds between transfers; only pready qualifies it
        q_d.pready = 1'b0;
        q_d.pslverr = 1'b0;
        if (i_psel && !i_penable) begin
            q_d.pready = 1'b1;
            q_d.pslverr = err;
            q_d.prdata = err ? 32'h00000000 : rd;
        end
        wr = i_psel && i_penable && q_q.pready && i_pwrite && !q_q.pslverr;

        if (wr) begin
            case (grp)
                `AIO_OFF_FLAGS >> 4: begin
                    if (word_is(i_paddr, `AIO_OFF_STS)) begin
                        ev_clr = i_pwdata[7:0];
                    end else if (word_is(i_paddr, `AIO_OFF_MASK)) begin
                        q_d.mask = i_pwdata[7:0];
                    end
                end
                `AIO_OFF_CFG >> 4: begin
                    q_d.rng[ch] = range_t'(i_pwdata[`AIO_CFG_RNG_LSB +: 3]);
                    q_d.filt[ch] = i_pwdata[`AIO_CFG_FILT_LSB +: FILT_W];
                    q_d.in_sc[ch] = i_pwdata[`AIO_CFG_IN_SC_BIT];
                    q_d.in_cl[ch] = i_pwdata[`AIO_CFG_IN_CL_BIT];
                    q_d.out_sc[ch] = i_pwdata[`AIO_CFG_OUT_SC_BIT];
                    q_d.out_cl[ch] = i_pwdata[`AIO_CFG_OUT_CL_BIT];
                    // restart the average so old-range samples are not mixed in
                    q_d.acc[ch] = '0;
                    q_d.cnt[ch] = '0;
                end
                `AIO_OFF_IN_RAW_LIM >> 4: begin
                    q_d.in_rmin[ch] = i_pwdata[`AIO_LIM_MIN_LSB +: 16];
                    q_d.in_rmax[ch] = i_pwdata[`AIO_LIM_MAX_LSB +: 16];
                end
                `AIO_OFF_IN_EU_LIM >> 4: begin
                    q_d.in_emin[ch] = i_pwdata[`AIO_LIM_MIN_LSB +: 16];
                    q_d.in_emax[ch] = i_pwdata[`AIO_LIM_MAX_LSB +: 16];
                end
                `AIO_OFF_OUT_EU_LIM >> 4: begin
                    q_d.out_emin[ch] = i_pwdata[`AIO_LIM_MIN_LSB +: 16];
                    q_d.out_emax[ch] = i_pwdata[`AIO_LIM_MAX_LSB +: 16];
                end
                `AIO_OFF_OUT_RAW_LIM >> 4: begin
                    q_d.out_rmin[ch] = i_pwdata[`AIO_LIM_MIN_LSB +: 16];
                    q_d.out_rmax[ch] = i_pwdata[`AIO_LIM_MAX_LSB +: 16];
                end
                `AIO_OFF_SCALED_OUT >> 4: q_d.out_eu[ch] = i_pwdata[15:0];
                default: begin
                end
            endcase
        end

        // sticky events: a set in the clearing cycle survives
        q_d.sts = (q_q.sts & ~ev_clr) | ev_set;
        q_d.irq = |(q_d.sts & q_d.mask);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            q_q <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                q_q.rng[c] <= range_t'(`AIO_RST_RANGE);
                // open limits make enabled scaling an identity on the positive half
                q_q.in_rmin[c] <= `AIO_RST_LIM_MIN;
                q_q.in_rmax[c] <= `AIO_RST_LIM_MAX;
                q_q.in_emin[c] <= `AIO_RST_LIM_MIN;
                q_q.in_emax[c] <= `AIO_RST_LIM_MAX;
                q_q.out_emin[c] <= `AIO_RST_LIM_MIN;
                q_q.out_emax[c] <= `AIO_RST_LIM_MAX;
                q_q.out_rmin[c] <= `AIO_RST_LIM_MIN;
                q_q.out_rmax[c] <= `AIO_RST_LIM_MAX;
            end
            q_q.mask <= `AIO_RST_MASK;
        end else begin
            q_q <= q_d;
        end
    end

    assign o_prdata = q_q.prdata;
    assign o_pready = q_q.pready;
    assign o_pslverr = q_q.pslverr;
    assign o_fault_flags = 8'(q_q.flags);
    assign o_dac_code = q_q.raw_out;
    assign o_irq = q_q.irq;
endmodule

// ===== sim/host_apb_model.sv
// host-side register bus master model for the range/scaling block
// assumes the block's clock; a transfer waits for ready without limit
`timescale 1ns/1ps
module host_apb_model (
    input wire logic i_clk_sys,
    input wire logic i_pready,
    input wire logic [31:0] i_prdata,
    input wire logic i_pslverr,
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata
);
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
    end

    // request held until ready is seen at an edge; the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
        @(posedge i_clk_sys);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clk_sys);
        o_penable <= 1'b1;
        do @(posedge i_clk_sys); while (i_pready !== 1'b1);
        q = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask
endmodule

// ===== sim/aio_rss_asserts.sv
// port checker for the range/scaling block, bound from the testbench
// assumes one clock and the synchronous active-low reset
`timescale 1ns/1ps
module aio_rss_checker #(
    parameter int NUM_CH = 4,
    parameter int FILT_W = 3
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_adc_valid,
    input wire logic [1:0] i_adc_chan,
    input wire logic [17:0] i_adc_data,
    input wire logic [7:0] o_fault_flags,
    input wire logic [NUM_CH-1:0][15:0] o_dac_code,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_sample_low;
        i_adc_valid && ($signed(i_adc_data) < -33095);
    endsequence

    a_ready_next: assert property (s_setup |=> o_pready)
        else $error("ready missing after setup");
    a_ready_single: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (o_pready |-> $past(i_psel && !i_penable))
        else $error("ready without setup");
    a_err_zero: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error answer malformed");
    a_flag_upper: assert property (o_fault_flags[7:4] == 4'h0)
        else $error("upper status nibble set");
    a_flag_quiet: assert property (!i_adc_valid |=> $stable(o_fault_flags))
        else $error("flags moved without sample");
    a_flag_other: assert property (i_adc_valid |=> ((o_fault_flags ^ $past(o_fault_flags))
        & ~(8'h01 << $past(i_adc_chan))) == 8'h00)
        else $error("flag of other channel moved");
    a_flag_low: assert property (s_sample_low |=> o_fault_flags[$past(i_adc_chan)])
        else $error("low sample not flagged");
    a_flag_clear: assert property (i_adc_valid && $signed(i_adc_data) inside {[3277:32768]}
        |=> !o_fault_flags[$past(i_adc_chan)])
        else $error("in-range sample left flag");
    a_dac_cause: assert property ($changed(o_dac_code)
        |-> $past(i_psel && i_pwrite) || $past(i_psel && i_pwrite, 2))
        else $error("output word moved without write");
    a_irq_rise: assert property ($rose(o_irq) |-> $past(i_adc_valid)
        || $past(i_psel && i_pwrite) || $past(i_psel && i_pwrite, 2))
        else $error("irq rose without cause");
    a_irq_fall: assert property ($fell(o_irq)
        |-> $past(i_psel && i_pwrite) || $past(i_psel && i_pwrite, 2))
        else $error("irq fell without write");
endmodule

// ===== sim/testbench.sv
// self-checking bench: register bus via host model, samples driven directly
// assumes a 100 ns clock and default parameters of the block
`timescale 1ns/1ps
bind aio_range_scale_status aio_rss_checker #(.NUM_CH(NUM_CH), .FILT_W(FILT_W)) chk_i (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_adc_valid(i_adc_valid),
    .i_adc_chan(i_adc_chan), .i_adc_data(i_adc_data), .o_fault_flags(o_fault_flags),
    .o_dac_code(o_dac_code), .o_irq(o_irq));
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic vld = 1'b0;
    logic [1:0] ch = 2'h0;
    logic [17:0] dat = 18'h0;
    logic psel, penable, pwrite, pready, pslverr, irq, e;
    logic [7:0] paddr, flags, ef;
    logic [31:0] pwdata, prdata, q;
    logic [3:0][15:0] dac;
    int fail_count = 0;
    int cmp_count = 0;
    int lo[6] = '{-32768, 3277, -163, -327, -32768, -33095};
    int hi[6] = '{32768, 131071, 32768, 33095, 32768, 33095};
    int rmin[6] = '{-32768, 6553, 0, 0, -32768, -32768};
    int sv[5] = '{15, -15, 2000, 2000, -15};
    int se[5] = '{2, -2, 200, 100, 0};
    int ov[4] = '{50, 150, 150, -10};
    int oe[4] = '{16000, 32767, 32000, 0};
    int v, x;

    always #50 clk = ~clk;

    host_apb_model host_apb_model_i (.i_clk_sys(clk), .i_pready(pready), .i_prdata(prdata),
        .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata));
    aio_range_scale_status aio_range_scale_status_i (.i_clk_sys(clk), .i_rstn(rstn),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_adc_valid(vld), .i_adc_chan(ch), .i_adc_data(dat), .o_fault_flags(flags),
        .o_dac_code(dac), .o_irq(irq));

    task note(input bit bad, input string m);
        cmp_count++;
        if (bad) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task chk_pin(input logic [31:0] got, input logic [31:0] exp, input string m);
        note(got !== exp, m);
    endtask
    task rd(input logic [7:0] a);
        host_apb_model_i.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task chk_reg(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        note(q !== exp || e !== 1'b0, $sformatf("read %h gave %h", a, q));
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        host_apb_model_i.xfer(1'b1, a, d, q, e);
    endtask
    // one sample pulse, then wait until flags and words have landed
    task smp(input int c, input int d);
        @(posedge clk);
        vld <= 1'b1;
        ch <= c[1:0];
        dat <= d[17:0];
        @(posedge clk);
        vld <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog", $time);
        stop_test;
    end

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        ef = 8'h00;
        chk_reg(8'h00, 32'h0);
        chk_reg(8'h08, 32'h0);
        chk_reg(8'h10, 32'h3);
        chk_reg(8'h40, 32'h7FFF_0000);
        wr(8'h00, 32'hFF);
        chk_reg(8'h00, 32'h0);
        rd(8'hFC);
        chk_pin(q, 32'h0, "unmapped data");
        chk_pin({31'h0, e}, 32'h1, "unmapped error");
        $display("test reset_map done");
        // each range on channel r%4: both thresholds, one step outside each, and midscale 16384
        for (int r = 0; r < 6; r++) begin
            wr(8'h10 + 8'(4 * (r % 4)), 32'(r));
            for (int i = 0; i < 5; i++) begin
                v = (i == 0) ? lo[r] - 1 : (i == 1) ? lo[r] : (i == 2) ? hi[r]
                    : (i == 3) ? hi[r] + 1 : 16384;
                smp(r % 4, v);
                if (v > 131071) v -= 262144;
                ef[r % 4] = (v < lo[r] || v > hi[r]);
                x = (v < rmin[r]) ? rmin[r] : (v > 32767) ? 32767 : v;
                chk_pin(32'(flags), 32'(ef), "fault flags");
                rd(8'h20 + 8'(4 * (r % 4)));
                chk_pin(32'(q[15:0]), 32'(x[15:0]), "raw word");
            end
        end
        $display("test ranges done");
        wr(8'h10, 32'h3);
        wr(8'h04, 32'hFF);
        wr(8'h08, 32'h01);
        settle;
        chk_pin(32'(irq), 32'h0, "irq idle");
        smp(0, 40000);
        chk_reg(8'h04, 32'h11);
        chk_pin(32'(irq), 32'h1, "irq fault");
        wr(8'h08, 32'h00);
        settle;
        chk_pin(32'(irq), 32'h0, "irq masked");
        wr(8'h08, 32'h10);
        settle;
        chk_pin(32'(irq), 32'h1, "irq new average");
        wr(8'h04, 32'h11);
        settle;
        chk_reg(8'h04, 32'h0);
        chk_pin(32'(irq), 32'h0, "irq cleared");
        $display("test irq done");
        // four-sample window; floor of a negative mean
        wr(8'h14, 32'h14);
        for (int i = 0; i < 4; i++) begin
            smp(1, (i == 3) ? -5 : -(i + 1));
            rd(8'h24);
            chk_pin(32'(q[15:0]), (i < 3) ? 32'h4000 : 32'hFFFD, "average");
        end
        $display("test filter done");
        wr(8'h40, 32'h03E8_0000);
        wr(8'h50, 32'h0064_0000);
        wr(8'h10, 32'h44);
        for (int i = 0; i < 5; i++) begin
            if (i == 3) wr(8'h10, 32'hC4);
            smp(0, sv[i]);
            chk_reg(8'h30, 32'(se[i]));
        end
        $display("test in_scale done");
        wr(8'h60, 32'h0064_0000);
        wr(8'h70, 32'h7D00_0000);
        wr(8'h10, 32'h104);
        for (int i = 0; i < 4; i++) begin
            if (i == 2) wr(8'h10, 32'h304);
            wr(8'h80, 32'(ov[i]));
            @(posedge clk);
            #1;
            chk_pin(32'(dac[0]), 32'(oe[i]), "dac code");
            rd(8'h90);
            chk_pin(32'(q[15:0]), 32'(oe[i]), "raw output");
        end
        wr(8'h8C, 32'h1234);
        @(posedge clk);
        #1;
        chk_pin(32'(dac[3]), 32'h1234, "unscaled output");
        $display("test out_scale done");
        stop_test;
    end
endmodule
